// file: inc/nvm_seq_pkg.sv
// constants and types for the nvm command sequencer and its word memory
// assumes a 40 MHz bus clock and classic wishbone register access
`default_nettype none

package nvm_seq_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_INDEX = 8'h04;
   localparam logic [7:0] OFF_CMDWORD = 8'h08;
   localparam logic [7:0] OFF_CLKDIV = 8'h0C;
   localparam logic [7:0] OFF_CONFIG = 8'h10;
   localparam logic [7:0] OFF_PROTECT = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFF_VERSION = 8'h20;
   // status bit positions
   localparam int STS_COMMAND_COMPLETE_FLAG = 7;
   localparam int STS_ACCESS_ERROR_FLAG = 5;
   localparam int STS_PROTECTION_VIOLATION_FLAG = 4;
   // interrupt event bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ACCESS_ERROR_FLAG = 1;
   localparam int IRQ_PROTECTION_VIOLATION_FLAG = 2;
   // config and protect bit positions
   localparam int CFG_FORCE_DBL = 1;
   localparam int PROT_EN = 7;
   // reset values
   localparam logic [7:0] CLKDIV_RST = 8'h27;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] PROTECT_RST = 8'h00;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   // command word index values
   localparam logic [2:0] IDX_WORD0 = 3'h0;
   localparam logic [2:0] IDX_WORD2 = 3'h2;
   localparam logic [2:0] IDX_LAST = 3'h5;
   // command codes
   localparam logic [7:0] CMD_EV_BLOCK = 8'h08;
   localparam logic [7:0] CMD_SET_FIELD_MARGIN = 8'h0E;
   localparam logic [7:0] CMD_EV_SECTION = 8'h10;
   localparam logic [7:0] CMD_PROG_EE = 8'h11;
   // command durations in bus cycles, PROG_EE_OP in operation clock ticks
   localparam logic [10:0] EV_SECTION_BUS = 11'd583;
   localparam logic [10:0] EV_BLOCK_BUS = 11'd631;
   localparam logic [10:0] PROG_EE_BUS = 11'd1678;
   localparam logic [6:0] PROG_EE_OP = 7'd68;
   localparam logic [10:0] SET_MARGIN_BUS = 11'd448;
   // global address map
   localparam logic [23:0] EE_BASE = 24'h10_0000;
   localparam logic [23:0] EE_END = 24'h10_0080;
   localparam logic [23:0] PF_BASE = 24'hFF_C000;
   localparam logic [16:0] EE_WORDS = 17'd64;
   localparam logic [15:0] MARGIN_MAX = 16'h0004;
   localparam logic [1:0] MG_FAIL = 2'b11;
   // version word in the information row
   localparam logic [23:0] IFR_VERSION_ADDR = 24'h1F_C0B6;
   localparam logic [3:0] VERSION_NONE = 4'h0;
   localparam logic [3:0] VERSION_FIRST = 4'h1;
   // sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

`default_nettype wire

// file: verilog/eeprom_word_mem.sv
// eeprom word storage with one write port and a registered read port
// assumes reset is held long enough to mark every word erased
`default_nettype none

module eeprom_word_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64,
   parameter int AW = 6,
   parameter logic [WIDTH-1:0] ERASED = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // read port
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH]; // storage words

   // reset erases all words, otherwise write then registered read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= ERASED;
         end
      end else if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   // read data from a register
   always_ff @(posedge clk_i) begin
      rd_data_o <= mem_reg[rd_addr_i];
   end
endmodule // eeprom_word_mem

`default_nettype wire

// file: verilog/nvm_command_sequencer.sv
// nvm command launch, error checking, eeprom verify and program timing
// assumes a classic wishbone master and synchronous array read inputs
`default_nettype none

module nvm_command_sequencer
   import nvm_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // mode select
   input wire logic special_mode_i,
   // flash array read path
   input wire logic arr_rd_req_i,
   input wire logic [23:0] arr_rd_addr_i,
   input wire logic [15:0] arr_data_i,
   input wire logic arr_ecc_dbl_i,
   output logic [15:0] arr_rd_data_o,
   output logic arr_rd_valid_o,
   output logic arr_rd_invalid_o,
   // status outputs
   output logic command_complete_o,
   output logic [2:0] margin_level_o,
   output logic irq_o
);
   // bus answer registers
   logic ack_reg; // one-cycle acknowledge
   logic [31:0] dat_reg; // read data
   // status flags
   logic command_complete_flag_reg;
   logic access_error_flag_reg;
   logic protection_violation_flag_reg;
   logic [1:0] margin_check_status_reg;
   // command object
   logic [2:0] command_word_index_reg;
   logic [15:0] command_object_word_reg [6];
   // mode-dependent control registers
   logic [7:0] nvm_clock_divider_reg;
   logic [7:0] nvm_config_reg;
   logic [7:0] eeprom_protect_reg;
   logic [2:0] margin_reg; // applied margin level
   // interrupt registers
   logic [2:0] irq_status_reg;
   logic [2:0] irq_mask_reg;
   logic irq_reg;
   // sequencer state
   seq_state_t state_reg;
   logic [10:0] bus_cnt_reg; // bus cycles left
   logic [6:0] op_cnt_reg; // operation clock ticks left
   logic [7:0] div_cnt_reg; // operation clock divider
   logic [5:0] scan_addr_reg; // word being blank checked
   logic [6:0] scan_left_reg; // words still to check
   logic scan_pend_reg; // read data due this cycle
   logic blank_fail_reg; // a non-erased word was seen
   // array read answer
   logic [15:0] arr_rd_data_reg;
   logic arr_rd_valid_reg;
   logic arr_rd_invalid_reg;
   logic [15:0] mem_rd_data; // memory read data

   // bus decode
   wire req = cyc_i & stb_i & ~ack_reg;
   wire wr = req & we_i & sel_i[0];
   wire wr_status = wr & (adr_i == OFF_STATUS);
   wire wr_index = wr & (adr_i == OFF_INDEX);
   wire wr_cmdword = req & we_i & (adr_i == OFF_CMDWORD);
   wire wr_clkdiv = wr & (adr_i == OFF_CLKDIV);
   wire wr_config = wr & (adr_i == OFF_CONFIG);
   wire wr_protect = wr & (adr_i == OFF_PROTECT);
   wire wr_irq_status = wr & (adr_i == OFF_IRQ_STATUS);
   wire wr_irq_mask = wr & (adr_i == OFF_IRQ_MASK);
   wire idx_ok = command_word_index_reg <= IDX_LAST;

   // command fields
   wire [15:0] word0 = command_object_word_reg[0];
   wire [15:0] word1 = command_object_word_reg[1];
   wire [15:0] word2 = command_object_word_reg[2];
   wire [7:0] cmd_code = word0[15:8];
   wire [23:0] gaddr = {word0[7:0], word1};
   wire [5:0] ee_word = gaddr[6:1];
   wire [16:0] sec_span = 17'(ee_word) + 17'(word2);
   wire in_ee = (gaddr >= EE_BASE) & (gaddr < EE_END) & ~gaddr[0];
   wire in_pf = (gaddr >= PF_BASE) & ~gaddr[0];
   wire is_sfm = cmd_code == CMD_SET_FIELD_MARGIN;
   wire is_evs = cmd_code == CMD_EV_SECTION;
   wire is_evb = cmd_code == CMD_EV_BLOCK;
   wire is_prg = cmd_code == CMD_PROG_EE;

   // launch checks, each a reason for an access error, prot_err for a protection violation
   wire sfm_idx_err = command_word_index_reg != IDX_WORD2;
   wire sfm_mode_err = ~special_mode_i;
   wire sfm_addr_err = ~(in_pf | in_ee);
   wire sfm_lvl_err = word2 > MARGIN_MAX;
   wire err_sfm = is_sfm & (sfm_idx_err | sfm_mode_err | sfm_addr_err | sfm_lvl_err);
   wire evs_rng_err = (word2 == 16'h0000) | (sec_span > EE_WORDS);
   wire err_evs = is_evs & ((command_word_index_reg != IDX_WORD2) | ~in_ee | evs_rng_err);
   wire err_evb = is_evb & ((command_word_index_reg != IDX_WORD0) | (word0[7:0] != EE_BASE[23:16]));
   wire err_prg = is_prg & ((command_word_index_reg != IDX_WORD2) | ~in_ee);
   wire err_unk = ~(is_sfm | is_evs | is_evb | is_prg);
   wire acc_err = err_sfm | err_evs | err_evb | err_prg | err_unk;
   wire prot_err = is_prg & ~acc_err & eeprom_protect_reg[PROT_EN];

   // launch by writing one to the complete flag while it is set
   wire launch = wr_status & dat_i[STS_COMMAND_COMPLETE_FLAG] & command_complete_flag_reg
                 & ~access_error_flag_reg & ~protection_violation_flag_reg;
   wire start_ok = launch & ~acc_err & ~prot_err;
   wire err_ev = launch & acc_err;
   wire prot_ev = launch & prot_err;

   // sequencer progress
   wire op_tick = div_cnt_reg >= nvm_clock_divider_reg; // lowered divider: no wrap wait
   wire scan_go = (state_reg == SEQ_RUN) & (scan_left_reg != 7'd0);
   wire seq_done = (state_reg == SEQ_RUN) & (bus_cnt_reg == 11'd0) & (op_cnt_reg == 7'd0)
                   & ~scan_go & ~scan_pend_reg;
   wire word_dirty = scan_pend_reg & (mem_rd_data != ERASED_WORD);
   wire [2:0] irq_events = {prot_ev, err_ev, seq_done};

   // read data selection
   wire [15:0] cmd_rd = idx_ok ? command_object_word_reg[command_word_index_reg] : 16'h0000;
   wire [7:0] status_rd = {command_complete_flag_reg, 1'b0, access_error_flag_reg,
                           protection_violation_flag_reg, 2'b00, margin_check_status_reg};
   wire [15:0] version_word = {12'h000, VERSION_FIRST};
   wire [31:0] rd_mux =
      (adr_i == OFF_STATUS) ? {24'h000000, status_rd} :
      (adr_i == OFF_INDEX) ? {29'h00000000, command_word_index_reg} :
      (adr_i == OFF_CMDWORD) ? {16'h0000, cmd_rd} :
      (adr_i == OFF_CLKDIV) ? {24'h000000, nvm_clock_divider_reg} :
      (adr_i == OFF_CONFIG) ? {24'h000000, nvm_config_reg} :
      (adr_i == OFF_PROTECT) ? {24'h000000, eeprom_protect_reg} :
      (adr_i == OFF_IRQ_STATUS) ? {29'h00000000, irq_status_reg} :
      (adr_i == OFF_IRQ_MASK) ? {29'h00000000, irq_mask_reg} :
      (adr_i == OFF_VERSION) ? {16'h0000, version_word} : 32'h00000000;

   // array read path decode
   wire ifr_hit = arr_rd_addr_i == IFR_VERSION_ADDR;
   wire dbl_fault = arr_ecc_dbl_i | nvm_config_reg[CFG_FORCE_DBL];

   // bus answer: ack one cycle after the request, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req;
         if (req) dat_reg <= rd_mux; // read data stands with ack
      end
   end
   // status flags: set by hardware wins over software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         command_complete_flag_reg <= 1'b1;
         access_error_flag_reg <= 1'b0;
         protection_violation_flag_reg <= 1'b0;
         margin_check_status_reg <= 2'b00;
      end else begin
         if (start_ok) command_complete_flag_reg <= 1'b0;
         else if (seq_done) command_complete_flag_reg <= 1'b1;
         if (err_ev) access_error_flag_reg <= 1'b1;
         else if (wr_status & dat_i[STS_ACCESS_ERROR_FLAG]) access_error_flag_reg <= 1'b0;
         if (prot_ev) protection_violation_flag_reg <= 1'b1;
         else if (wr_status & dat_i[STS_PROTECTION_VIOLATION_FLAG]) protection_violation_flag_reg <= 1'b0;
         if (launch) margin_check_status_reg <= 2'b00;
         else if (seq_done & blank_fail_reg) margin_check_status_reg <= MG_FAIL;
      end
   end
   // command object loads only while no command runs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         command_word_index_reg <= IDX_WORD0;
         for (int i = 0; i < 6; i++) begin
            command_object_word_reg[i] <= 16'h0000;
         end
      end else if (command_complete_flag_reg) begin
         if (wr_index) command_word_index_reg <= dat_i[2:0];
         if (wr_cmdword & idx_ok & sel_i[0]) begin
            command_object_word_reg[command_word_index_reg][7:0] <= dat_i[7:0];
         end
         if (wr_cmdword & idx_ok & sel_i[1]) begin
            command_object_word_reg[command_word_index_reg][15:8] <= dat_i[15:8];
         end
      end
   end

   // mode-dependent writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nvm_clock_divider_reg <= CLKDIV_RST;
         nvm_config_reg <= CONFIG_RST;
         eeprom_protect_reg <= PROTECT_RST;
      end else begin
         // normal mode: divider only while idle, special: any time
         if (wr_clkdiv & (special_mode_i | command_complete_flag_reg)) begin
            nvm_clock_divider_reg <= dat_i[7:0];
         end
         // config writable in special mode only
         if (wr_config & special_mode_i) nvm_config_reg <= dat_i[7:0];
         // normal mode may only add protection
         if (wr_protect) begin
            eeprom_protect_reg <= special_mode_i ? dat_i[7:0]
                                  : (eeprom_protect_reg | dat_i[7:0]);
         end
      end
   end

   // operation clock enable divider, free running
   always_ff @(posedge clk_i) begin
      if (rst_i | op_tick) begin
         div_cnt_reg <= 8'h00;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // sequencer: load durations at launch, count down, finish
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= SEQ_IDLE;
         bus_cnt_reg <= 11'd0;
         op_cnt_reg <= 7'd0;
         margin_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            SEQ_IDLE: begin
               if (start_ok) begin
                  state_reg <= SEQ_RUN;
                  op_cnt_reg <= is_prg ? PROG_EE_OP : 7'd0;
                  if (is_evs) begin
                     bus_cnt_reg <= EV_SECTION_BUS - 11'd1;
                  end else if (is_evb) begin
                     bus_cnt_reg <= EV_BLOCK_BUS - 11'd1;
                  end else if (is_prg) begin
                     bus_cnt_reg <= PROG_EE_BUS - 11'd1;
                  end else begin
                     bus_cnt_reg <= SET_MARGIN_BUS - 11'd1;
                     margin_reg <= word2[2:0];
                  end
               end
            end
            SEQ_RUN: begin
               // bus phase first, then operation clock ticks
               if (bus_cnt_reg != 11'd0) begin
                  bus_cnt_reg <= bus_cnt_reg - 11'd1;
               end else if (op_tick & (op_cnt_reg != 7'd0)) begin
                  op_cnt_reg <= op_cnt_reg - 7'd1;
               end
               if (seq_done) state_reg <= SEQ_IDLE;
            end
         endcase
      end
   end

   // blank check scan over the selected eeprom words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scan_addr_reg <= 6'h00;
         scan_left_reg <= 7'd0;
         scan_pend_reg <= 1'b0;
         blank_fail_reg <= 1'b0;
      end else if (start_ok) begin
         scan_addr_reg <= is_evs ? ee_word : 6'h00;
         scan_left_reg <= is_evs ? word2[6:0] : (is_evb ? EE_WORDS[6:0] : 7'd0);
         scan_pend_reg <= 1'b0;
         blank_fail_reg <= 1'b0;
      end else begin
         scan_pend_reg <= scan_go;
         if (scan_go) begin
            scan_addr_reg <= scan_addr_reg + 6'h01;
            scan_left_reg <= scan_left_reg - 7'd1;
         end
         if (word_dirty) blank_fail_reg <= 1'b1;
      end
   end
   // interrupt status: events set, write one clears, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= 3'h0;
         irq_mask_reg <= 3'h0;
         irq_reg <= 1'b0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? dat_i[2:0] : 3'h0)) | irq_events;
         if (wr_irq_mask) irq_mask_reg <= dat_i[2:0];
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end
   // array read answer: version word or array data, ecc tag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arr_rd_data_reg <= 16'h0000;
         arr_rd_valid_reg <= 1'b0;
         arr_rd_invalid_reg <= 1'b0;
      end else begin
         arr_rd_valid_reg <= arr_rd_req_i;
         if (arr_rd_req_i) arr_rd_data_reg <= ifr_hit ? version_word : arr_data_i;
         arr_rd_invalid_reg <= arr_rd_req_i & ~ifr_hit & dbl_fault;
      end
   end

   // eeprom storage: program writes one word, scan reads
   eeprom_word_mem #(
      .WIDTH(16),
      .DEPTH(64),
      .AW(6),
      .ERASED(ERASED_WORD)
   ) u_eeprom (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(start_ok & is_prg),
      .wr_addr_i(ee_word),
      .wr_data_i(word2),
      .rd_addr_i(scan_addr_reg),
      .rd_data_o(mem_rd_data)
   );

   // outputs straight from flip-flops
   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
   assign arr_rd_data_o = arr_rd_data_reg;
   assign arr_rd_valid_o = arr_rd_valid_reg;
   assign arr_rd_invalid_o = arr_rd_invalid_reg;
   assign command_complete_o = command_complete_flag_reg;
   assign margin_level_o = margin_reg;
   assign irq_o = irq_reg;
endmodule // nvm_command_sequencer

`default_nettype wire

// file: tb/nvm_seq_checker.sv
// port checker for the nvm command sequencer
// assumes it is bound onto nvm_command_sequencer
`default_nettype none

module nvm_seq_checker
   import nvm_seq_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // array read and status
   input wire logic arr_rd_req_i,
   input wire logic [23:0] arr_rd_addr_i,
   input wire logic arr_ecc_dbl_i,
   input wire logic [15:0] arr_rd_data_o,
   input wire logic arr_rd_valid_o,
   input wire logic arr_rd_invalid_o,
   input wire logic command_complete_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [11:0] busy_reg; // cycles the complete flag has been low

   // busy length counter, cleared while complete
   always_ff @(posedge clk_i) begin
      if (rst_i || command_complete_o) busy_reg <= 12'h000;
      else if (busy_reg != 12'hFFF) busy_reg <= busy_reg + 12'h001; // saturate, long programs
   end

   property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not acked next cycle");
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");
   property p_unmapped; ack_o && !we_i && adr_i > OFF_VERSION |-> dat_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_arr_valid; arr_rd_req_i |=> arr_rd_valid_o; endproperty
   a_arr_valid: assert property (p_arr_valid)
      else $error("array answer missing");
   property p_arr_ecc;
      arr_rd_req_i && arr_ecc_dbl_i && arr_rd_addr_i != IFR_VERSION_ADDR |=> arr_rd_invalid_o;
   endproperty
   a_arr_ecc: assert property (p_arr_ecc)
      else $error("double fault not tagged");
   property p_version;
      arr_rd_req_i && arr_rd_addr_i == IFR_VERSION_ADDR
         |=> !arr_rd_invalid_o && arr_rd_data_o[3:0] == VERSION_FIRST;
   endproperty
   a_version: assert property (p_version)
      else $error("version word wrong");
   property p_launch;
      $fell(command_complete_o)
         |-> $past(cyc_i) && $past(stb_i) && $past(we_i) && $past(adr_i) == OFF_STATUS
         && $past(dat_i[STS_COMMAND_COMPLETE_FLAG]);
   endproperty
   a_launch: assert property (p_launch)
      else $error("complete flag fell without launch");
   property p_busy_len;
      $rose(command_complete_o) |-> busy_reg == EV_SECTION_BUS || busy_reg == EV_BLOCK_BUS
         || busy_reg == SET_MARGIN_BUS || busy_reg >= 12'h6D2;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("command length wrong");
   c_launch: cover property ($fell(command_complete_o));
   c_done: cover property ($rose(command_complete_o));
   c_invalid: cover property (arr_rd_valid_o && arr_rd_invalid_o);
endmodule // nvm_seq_checker

bind nvm_command_sequencer nvm_seq_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .dat_o(dat_o), .ack_o(ack_o), .arr_rd_req_i(arr_rd_req_i),
   .arr_rd_addr_i(arr_rd_addr_i), .arr_ecc_dbl_i(arr_ecc_dbl_i),
   .arr_rd_data_o(arr_rd_data_o), .arr_rd_valid_o(arr_rd_valid_o),
   .arr_rd_invalid_o(arr_rd_invalid_o), .command_complete_o(command_complete_o));

`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the nvm command sequencer
// assumes the port checker is bound onto the design
`default_nettype none

module testbench
   import nvm_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // stimulus, all driven after a rising edge
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'hF;
   logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, spc_i = 1'b0;
   logic req_i = 1'b0, ecc_i = 1'b0;
   logic [23:0] ra_i = 24'h0;
   logic [15:0] rd_i = 16'h0;
   // observed outputs
   logic [31:0] dat_o;
   logic [15:0] ard_o;
   logic ack_o, av_o, ai_o, cc_o, irq_o;
   logic [2:0] ml_o; // applied margin level
   int errors = 0, total_checks = 0, cycles = 0;
   logic [31:0] bus_q[$], arr_q[$]; // expected answers, oldest first
   logic [15:0] lf = 16'hDEB2; // random state, seed 57010

   nvm_command_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .special_mode_i(spc_i), .arr_rd_req_i(req_i), .arr_rd_addr_i(ra_i), .arr_data_i(rd_i),
      .arr_ecc_dbl_i(ecc_i), .arr_rd_data_o(ard_o), .arr_rd_valid_o(av_o),
      .arr_rd_invalid_o(ai_o), .command_complete_o(cc_o), .margin_level_o(ml_o), .irq_o(irq_o));

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one classic cycle, held until ack is sampled
   task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge clk_i);
      adr_i <= a;
      dat_i <= d;
      we_i <= w;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   // read with the expected value noted
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus_q.push_back(e);
      bus(a, 32'h0, 1'b0);
   endtask

   // load words 0-2, set index, launch; n counts busy cycles
   task automatic cmd(input logic [47:0] w, input logic [2:0] ix, output int n);
      for (int i = 0; i < 3; i++) begin
         bus(OFF_INDEX, 32'(i), 1'b1);
         bus(OFF_CMDWORD, {16'h0, w[47-16*i -: 16]}, 1'b1);
      end
      bus(OFF_INDEX, {29'h0, ix}, 1'b1);
      bus(OFF_STATUS, 32'h80, 1'b1);
      n = 0;
      while (cc_o !== 1'b1) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // compare answers against the oldest note; cut a hang short
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0)
         check(dat_o, bus_q.size() > 0 ? bus_q.pop_front() : 32'hX);
      if (av_o === 1'b1)
         check({15'h0, ai_o, ard_o}, arr_q.size() > 0 ? arr_q.pop_front() : 32'hX);
      cycles++;
      if (cycles > 12000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      int n;
      logic [15:0] v;
      logic [47:0] mc[4];
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, version, unmapped place
      rd(OFF_STATUS, 32'h80);
      rd(OFF_CLKDIV, 32'h27);
      rd(OFF_VERSION, {28'h0, VERSION_FIRST});
      rd(8'h40, 32'h0);
      $display("test reset done");
      // margin command refused in normal mode
      cmd(48'h0E10_0000_0002, 3'h2, n);
      check(32'(n), 32'h0);
      rd(OFF_STATUS, 32'hA0);
      bus(OFF_STATUS, 32'h20, 1'b1);
      // normal mode: config locked, protection may only grow
      bus(OFF_CONFIG, 32'h2, 1'b1);
      bus(OFF_PROTECT, 32'h80, 1'b1);
      bus(OFF_PROTECT, 32'h0, 1'b1);
      rd(OFF_CONFIG, 32'h0);
      rd(OFF_PROTECT, 32'h80);
      // protected program is refused, nothing runs
      cmd(48'h1110_0006_0000, 3'h2, n);
      check(32'(n), 32'h0);
      rd(OFF_STATUS, 32'h90);
      bus(OFF_STATUS, 32'h10, 1'b1);
      // special mode may drop protection again
      spc_i <= 1'b1;
      bus(OFF_PROTECT, 32'h0, 1'b1);
      rd(OFF_PROTECT, 32'h0);
      // bad index, address, level, then a good one; margin only ahead of verify
      mc = '{48'h0E10_0000_0002, 48'h0E20_0000_0002, 48'h0E10_0000_0005, 48'h0E10_0000_0002};
      for (int i = 0; i < 4; i++) begin
         cmd(mc[i], i == 0 ? 3'h1 : 3'h2, n);
         check(32'(n), i == 3 ? 32'(SET_MARGIN_BUS) : 32'h0);
         rd(OFF_STATUS, i == 3 ? 32'h80 : 32'hA0);
         bus(OFF_STATUS, 32'h20, 1'b1);
      end
      check({29'h0, ml_o}, 32'h2);
      $display("test margin done");
      // blank checks over erased eeprom
      cmd(48'h1010_0000_0040, 3'h2, n);
      check(32'(n), 32'(EV_SECTION_BUS));
      rd(OFF_STATUS, 32'h80);
      cmd(48'h0810_0000_0000, 3'h0, n);
      check(32'(n), 32'(EV_BLOCK_BUS));
      // program one random word, then the section check fails
      bus(OFF_CLKDIV, 32'h0, 1'b1);
      lf = lfsr(lf);
      v = lf & 16'h7FFF;
      cmd({16'h1110, 16'h0006, v}, 3'h2, n);
      check(32'(n >= 1746 && n <= 1748), 32'h1);
      cmd(48'h1010_0000_0004, 3'h2, n);
      rd(OFF_STATUS, 32'h83);
      $display("test verify done");
      // unmasked error raises irq, masked done does not
      bus(OFF_IRQ_STATUS, 32'h7, 1'b1);
      bus(OFF_IRQ_MASK, 32'h2, 1'b1);
      cmd(48'h0010_0000_0000, 3'h0, n);
      rd(OFF_IRQ_STATUS, 32'h2);
      check({31'h0, irq_o}, 32'h1);
      bus(OFF_STATUS, 32'h20, 1'b1);
      bus(OFF_IRQ_STATUS, 32'h2, 1'b1);
      cmd(48'h0810_0000_0000, 3'h0, n);
      rd(OFF_IRQ_STATUS, 32'h1);
      check({31'h0, irq_o}, 32'h0);
      $display("test irq done");
      // array reads: ecc tag, forced tag, version word
      for (int i = 0; i < 8; i++) begin
         if (i == 4) bus(OFF_CONFIG, 32'h2, 1'b1);
         @(posedge clk_i);
         lf = lfsr(lf);
         req_i <= 1'b1;
         ecc_i <= lf[0];
         rd_i <= lf;
         ra_i <= i == 7 ? IFR_VERSION_ADDR : {8'h00, lf};
         arr_q.push_back(i == 7 ? 32'h1 : {15'h0, lf[0] || i >= 4, lf});
         if (i == 3 || i == 7) begin
            @(posedge clk_i);
            req_i <= 1'b0;
         end
      end
      repeat (3) @(posedge clk_i);
      $display("test array done");
      test_done();
   end
endmodule // testbench

`default_nettype wire
